// ### dcbr_regs.sv
// module: channel 5 active code high byte and broadcast (page mask) register bank
//
// How it works
// - channel 5 active code bits 13..6 are a read/write byte at 0x31
// - broadcast active code: bits 5..0 in 0x32[7:2], bits 13..6 at 0x33
// - after broadcast active write, copy code into every selected channel only
// - channel choice byte 0x34: bit n selects channel n, bits 7..6 read zero
// - staged broadcast loads staged codes, active broadcast loads active codes
// - staged broadcast low bits in 0x35[7:2], copied to selected staged registers
// - reset clears every register, so no channel is selected
// - staged broadcast code bits 13..6 are a read/write byte at 0x36
// - write-only 0x37: bit n transfers staged code to active, self clearing
`default_nettype none
module dcbr_regs (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire dcbr_pkg::dcbr_req_t req,             // register access, same clock
  input  wire logic [7:0]         chan5_staged_hi,  // channel 5 staged code bits 13..6
  output logic [7:0]              rdata,            // read data, one cycle after rd
  output logic                    rd_hit,           // read addressed this bank
  output logic [7:0]              chan5_active_hi,  // channel 5 active code bits 13..6
  output dcbr_pkg::dcbr_copy_t    active_copy,      // one-cycle active code load order
  output dcbr_pkg::dcbr_copy_t    staged_copy,      // one-cycle staged code load order
  output logic [5:0]              soft_transfer_strobe // one-cycle transfer per channel
);

  logic [7:0] ch5_hi_ff;
  logic [5:0] bc_act_lo_ff;
  logic [7:0] bc_act_hi_ff;
  logic [5:0] choice_ff;
  logic [5:0] bc_stg_lo_ff;
  logic [7:0] bc_stg_hi_ff;
  logic [5:0] xfer_ff;
  logic [5:0] act_chans_ff;
  logic [5:0] stg_chans_ff;
  logic [7:0] rdata_ff;
  logic       rd_hit_ff;

  logic       wr_ch5;
  logic       wr_act_lo;
  logic       wr_act_hi;
  logic       wr_choice;
  logic       wr_stg_lo;
  logic       wr_stg_hi;
  logic       wr_xfer;
  logic       act_bcast;
  logic       stg_bcast;
  logic [7:0] nxt_act_hi;
  logic [7:0] nxt_rdata;
  logic       nxt_rd_hit;

  // write strobe for one offset
  function automatic logic hit_wr(input dcbr_pkg::dcbr_req_t r, input logic [7:0] ofs);
    hit_wr = r.wr && (r.addr == ofs);
  endfunction : hit_wr

  // address decode of the write strobes
  assign wr_ch5    = hit_wr(req, dcbr_pkg::OFS_CH5_ACT_HI);
  assign wr_act_lo = hit_wr(req, dcbr_pkg::OFS_BC_ACT_LO);
  assign wr_act_hi = hit_wr(req, dcbr_pkg::OFS_BC_ACT_HI);
  assign wr_choice = hit_wr(req, dcbr_pkg::OFS_BC_CHOICE);
  assign wr_stg_lo = hit_wr(req, dcbr_pkg::OFS_BC_STG_LO);
  assign wr_stg_hi = hit_wr(req, dcbr_pkg::OFS_BC_STG_HI);
  assign wr_xfer   = hit_wr(req, dcbr_pkg::OFS_SOFT_XFER);
  assign act_bcast = wr_act_lo | wr_act_hi;
  assign stg_bcast = wr_stg_lo | wr_stg_hi;
  // high byte as it stands after this write, so a high-byte write copies its new value
  assign nxt_act_hi = wr_act_hi ? req.wdata : bc_act_hi_ff;

  // channel 5 byte
  // direct write, broadcast copy and soft transfer are distinct offsets, never together
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ch5_hi_ff <= dcbr_pkg::RST_BYTE;
    end else if (wr_ch5) begin
      ch5_hi_ff <= req.wdata;
    end else if (act_bcast && choice_ff[dcbr_pkg::CHAN5]) begin
      ch5_hi_ff <= nxt_act_hi;
    end else if (wr_xfer && req.wdata[dcbr_pkg::CHAN5]) begin
      ch5_hi_ff <= chan5_staged_hi;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bc_act_lo_ff <= dcbr_pkg::RST_LO6;
      bc_act_hi_ff <= dcbr_pkg::RST_BYTE;
    end else begin
      if (wr_act_lo) begin
        bc_act_lo_ff <= req.wdata[7:dcbr_pkg::LO_POS];
      end
      if (wr_act_hi) begin
        bc_act_hi_ff <= req.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      choice_ff <= dcbr_pkg::RST_CHANS;
    end else if (wr_choice) begin
      choice_ff <= req.wdata[5:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bc_stg_lo_ff <= dcbr_pkg::RST_LO6;
      bc_stg_hi_ff <= dcbr_pkg::RST_BYTE;
    end else begin
      if (wr_stg_lo) begin
        bc_stg_lo_ff <= req.wdata[7:dcbr_pkg::LO_POS];
      end
      if (wr_stg_hi) begin
        bc_stg_hi_ff <= req.wdata;
      end
    end
  end

  // transfer bits clear by themselves the cycle after
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      act_chans_ff <= dcbr_pkg::RST_CHANS;
      stg_chans_ff <= dcbr_pkg::RST_CHANS;
      xfer_ff      <= dcbr_pkg::RST_CHANS;
    end else begin
      act_chans_ff <= act_bcast ? choice_ff : dcbr_pkg::RST_CHANS;
      stg_chans_ff <= stg_bcast ? choice_ff : dcbr_pkg::RST_CHANS;
      xfer_ff      <= wr_xfer ? req.wdata[5:0] : dcbr_pkg::RST_CHANS;
    end
  end

  // read mux; reserved bits and the write-only byte read zero
  always_comb begin
    nxt_rd_hit = req.rd;
    nxt_rdata  = dcbr_pkg::RD_ZERO;
    case (req.addr)
      dcbr_pkg::OFS_CH5_ACT_HI: nxt_rdata = ch5_hi_ff;
      dcbr_pkg::OFS_BC_ACT_LO:  nxt_rdata = {bc_act_lo_ff, 2'h0};
      dcbr_pkg::OFS_BC_ACT_HI:  nxt_rdata = bc_act_hi_ff;
      dcbr_pkg::OFS_BC_CHOICE:  nxt_rdata = {2'h0, choice_ff};
      dcbr_pkg::OFS_BC_STG_LO:  nxt_rdata = {bc_stg_lo_ff, 2'h0};
      dcbr_pkg::OFS_BC_STG_HI:  nxt_rdata = bc_stg_hi_ff;
      dcbr_pkg::OFS_SOFT_XFER:  nxt_rdata = dcbr_pkg::RD_ZERO;
      default: begin
        nxt_rdata  = dcbr_pkg::RD_ZERO;
        nxt_rd_hit = 1'b0;
      end
    endcase
    if (!req.rd) begin
      nxt_rdata = dcbr_pkg::RD_ZERO;
    end
  end

  // registered read answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff  <= dcbr_pkg::RD_ZERO;
      rd_hit_ff <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rd_hit_ff <= nxt_rd_hit;
    end
  end

  // outputs taken straight from flip-flops
  assign rdata                = rdata_ff;
  assign rd_hit               = rd_hit_ff;
  assign chan5_active_hi      = ch5_hi_ff;
  // whole carrier in one assignment, so each output keeps a single driver
  assign active_copy          = '{chans: act_chans_ff, code: {bc_act_hi_ff, bc_act_lo_ff}};
  assign staged_copy          = '{chans: stg_chans_ff, code: {bc_stg_hi_ff, bc_stg_lo_ff}};
  assign soft_transfer_strobe = xfer_ff;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_ch5_write_holds: assert property (
    wr_ch5 |=> chan5_active_hi == $past(req.wdata))
    else $error("channel 5 byte did not take written value");
  a_act_lo_reserved: assert property (
    req.rd && req.addr == dcbr_pkg::OFS_BC_ACT_LO |=> rdata[1:0] == 2'h0)
    else $error("reserved bits of active low byte not zero");
  a_act_copy_chans: assert property (
    act_bcast |=> (active_copy.chans == $past(choice_ff)
      && active_copy.code[13:6] == ($past(wr_act_hi) ? $past(req.wdata) : $past(bc_act_hi_ff))
      && active_copy.code[5:0] ==
         ($past(wr_act_lo) ? $past(req.wdata[7:2]) : $past(bc_act_lo_ff)))
      ##1 (active_copy.chans == 6'h00 || $past(act_bcast)))
    else $error("active copy order wrong");
  a_ch5_unselected: assert property (
    act_bcast && !choice_ff[5] |=> $stable(chan5_active_hi))
    else $error("unselected channel 5 changed");
  a_ch5_selected: assert property (
    act_bcast && choice_ff[5] |=> chan5_active_hi == active_copy.code[13:6])
    else $error("selected channel 5 missed broadcast");
  a_choice_reserved: assert property (
    req.rd && req.addr == dcbr_pkg::OFS_BC_CHOICE |=> rdata[7:6] == 2'h0 && rd_hit)
    else $error("reserved choice bits not zero");
  a_stg_copy_chans: assert property (
    stg_bcast |=> staged_copy.chans == $past(choice_ff)
      && staged_copy.code[5:0] ==
         ($past(wr_stg_lo) ? $past(req.wdata[7:2]) : $past(bc_stg_lo_ff)))
    else $error("staged copy order wrong");
  a_stg_hi_holds: assert property (
    wr_stg_hi |=> staged_copy.code[13:6] == $past(req.wdata) ##1 $stable(bc_stg_hi_ff)
      || $past(wr_stg_hi))
    else $error("staged high byte not held");
  a_xfer_self_clear: assert property (
    soft_transfer_strobe != 6'h00 |-> $past(wr_xfer))
    else $error("transfer strobe without write");
  a_xfer_reads_zero: assert property (
    req.rd && req.addr == dcbr_pkg::OFS_SOFT_XFER |=> rdata == 8'h00)
    else $error("write-only byte read non-zero");
  a_copy_from_either: assert property (
    wr_act_hi && !wr_act_lo |=> active_copy.code[5:0] == $past(bc_act_lo_ff))
    else $error("high-byte write lost low bits");

  c_act_broadcast: cover property (act_bcast && choice_ff == 6'h3f);
  c_stg_broadcast: cover property (stg_bcast && choice_ff != 6'h00);
  c_ch5_transfer:  cover property (wr_xfer && req.wdata[5]);
  c_no_selection:  cover property (act_bcast && choice_ff == 6'h00);

endmodule : dcbr_regs
`default_nettype wire

// ### dcbr_pkg.sv
// package: offsets, field layouts and carriers of the code broadcast register bank
`default_nettype none
package dcbr_pkg;
  // register offsets on the serial register interface
  localparam logic [7:0] OFS_CH5_ACT_HI   = 8'h31;
  localparam logic [7:0] OFS_BC_ACT_LO    = 8'h32;
  localparam logic [7:0] OFS_BC_ACT_HI    = 8'h33;
  localparam logic [7:0] OFS_BC_CHOICE    = 8'h34;
  localparam logic [7:0] OFS_BC_STG_LO    = 8'h35;
  localparam logic [7:0] OFS_BC_STG_HI    = 8'h36;
  localparam logic [7:0] OFS_SOFT_XFER    = 8'h37;

  // field layout
  localparam int         NUM_CHAN         = 6;
  localparam int         CODE_W           = 14;
  localparam int         LO_POS           = 2;   // low code bits sit in [7:2]
  localparam int         CHAN5            = 5;

  // values after reset
  localparam logic [7:0] RST_BYTE         = 8'h00;
  localparam logic [5:0] RST_LO6          = 6'h00;
  localparam logic [5:0] RST_CHANS        = 6'h00;
  localparam logic [7:0] RD_ZERO          = 8'h00;

  // one-cycle copy order towards the per-channel code registers
  typedef struct packed {
    logic [5:0]  chans;   // channels to load, bit n is channel n
    logic [13:0] code;    // 14-bit code to load
  } dcbr_copy_t;

  // register access from the serial interface engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dcbr_req_t;
endpackage : dcbr_pkg
`default_nettype wire

// ### dcbr_host.sv
// host model: drives register requests into the bank at rising edges
`default_nettype none
module dcbr_host (
  input  wire logic               clk,
  output var  dcbr_pkg::dcbr_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;

  // bus idles with no strobe
  initial req = '0;

  // one request, held until the edge that takes it; wr and rd never together
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    req <= '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge clk);
  endtask : put

  // release: address and data flip so stale values never pass for valid ones
  task automatic rel();
    req <= '{wr: 1'h0, rd: 1'h0, addr: ~req.addr, wdata: ~req.wdata};
  endtask : rel
endmodule : dcbr_host
`default_nettype wire

// ### test_dac_code_broadcast_regs.sv
// testbench: code broadcast register bank driven through the host model
`default_nettype none
module test_dac_code_broadcast_regs;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [7:0]  d;
    logic [7:0]  r;
    logic        h;
    logic [19:0] ac;
    logic [19:0] sc;
    logic [5:0]  sx;
    logic [7:0]  c5;
  } dcbr_row_t;

  logic                 clk = 1'h0;
  logic                 nrst = 1'h0;
  logic [7:0]           chan5_staged_hi = 8'ha5;
  dcbr_pkg::dcbr_req_t  req;
  logic [7:0]           rdata;
  logic                 rd_hit;
  logic [7:0]           chan5_active_hi;
  dcbr_pkg::dcbr_copy_t active_copy;
  dcbr_pkg::dcbr_copy_t staged_copy;
  logic [5:0]           soft_transfer_strobe;
  int                   error_cnt = 0;
  int                   tests_run = 0;

  // w, offset, data, rdata, hit, active copy, staged copy, strobe, chan5 high
  dcbr_row_t rows [18] = '{
    '{1'h1, 8'h34, 8'hff, 8'h00, 1'h0, 20'h00000, 20'h00000, 6'h00, 8'h00},
    '{1'h0, 8'h34, 8'h00, 8'h3f, 1'h1, 20'h00000, 20'h00000, 6'h00, 8'h00},
    '{1'h1, 8'h33, 8'h81, 8'h00, 1'h0, 20'hfe040, 20'h00000, 6'h00, 8'h81},
    '{1'h1, 8'h32, 8'hff, 8'h00, 1'h0, 20'hfe07f, 20'h00000, 6'h00, 8'h81},
    '{1'h0, 8'h32, 8'h00, 8'hfc, 1'h1, 20'h0207f, 20'h00000, 6'h00, 8'h81},
    '{1'h1, 8'h34, 8'h05, 8'h00, 1'h0, 20'h0207f, 20'h00000, 6'h00, 8'h81},
    '{1'h1, 8'h36, 8'h3c, 8'h00, 1'h0, 20'h0207f, 20'h14f00, 6'h00, 8'h81},
    '{1'h1, 8'h35, 8'h07, 8'h00, 1'h0, 20'h0207f, 20'h14f01, 6'h00, 8'h81},
    '{1'h0, 8'h35, 8'h00, 8'h04, 1'h1, 20'h0207f, 20'h00f01, 6'h00, 8'h81},
    '{1'h0, 8'h36, 8'h00, 8'h3c, 1'h1, 20'h0207f, 20'h00f01, 6'h00, 8'h81},
    '{1'h0, 8'h33, 8'h00, 8'h81, 1'h1, 20'h0207f, 20'h00f01, 6'h00, 8'h81},
    '{1'h0, 8'h31, 8'h00, 8'h81, 1'h1, 20'h0207f, 20'h00f01, 6'h00, 8'h81},
    '{1'h1, 8'h31, 8'h42, 8'h00, 1'h0, 20'h0207f, 20'h00f01, 6'h00, 8'h42},
    '{1'h1, 8'h33, 8'h99, 8'h00, 1'h0, 20'h1667f, 20'h00f01, 6'h00, 8'h42},
    '{1'h1, 8'h37, 8'h21, 8'h00, 1'h0, 20'h0267f, 20'h00f01, 6'h21, 8'ha5},
    '{1'h0, 8'h37, 8'h00, 8'h00, 1'h1, 20'h0267f, 20'h00f01, 6'h00, 8'ha5},
    '{1'h0, 8'h30, 8'h00, 8'h00, 1'h0, 20'h0267f, 20'h00f01, 6'h00, 8'ha5},
    '{1'h1, 8'h38, 8'hff, 8'h00, 1'h0, 20'h0267f, 20'h00f01, 6'h00, 8'ha5}
  };

  // 125 MHz clock
  always #4 clk = ~clk;

  dcbr_host host (
    .clk (clk),
    .req (req)
  );

  dcbr_regs dut (
    .clk                  (clk),
    .nrst                 (nrst),
    .req                  (req),
    .chan5_staged_hi      (chan5_staged_hi),
    .rdata                (rdata),
    .rd_hit               (rd_hit),
    .chan5_active_hi      (chan5_active_hi),
    .active_copy          (active_copy),
    .staged_copy          (staged_copy),
    .soft_transfer_strobe (soft_transfer_strobe)
  );

  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // one access; outputs looked at mid-cycle, when the one-cycle answers stand
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    host.put(w, a, d);
    host.rel();
    @(negedge clk);
  endtask : op

  task automatic chk_row(input dcbr_row_t e);
    chk(rdata, e.r, "read data");
    chk(rd_hit, e.h, "read hit");
    chk(active_copy, e.ac, "active copy");
    chk(staged_copy, e.sc, "staged copy");
    chk(soft_transfer_strobe, e.sx, "transfer strobe");
    chk(chan5_active_hi, e.c5, "chan5 high");
  endtask : chk_row

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    @(negedge clk);
    chk_row('0);
    foreach (rows[i]) begin
      op(rows[i].w, rows[i].a, rows[i].d);
      chk_row(rows[i]);
    end
    // choice written just before a back-to-back code write
    @(posedge clk);
    host.put(1'h1, 8'h34, 8'h20);
    host.put(1'h1, 8'h33, 8'h10);
    host.rel();
    @(negedge clk);
    chk(active_copy, 20'h8043f, "back to back copy");
    chk(chan5_active_hi, 8'h10, "back to back chan5");
    // each transfer bit alone; only bit 5 loads the local byte
    @(posedge clk);
    chan5_staged_hi <= 8'h3c;
    for (int n = 0; n < 6; n++) begin
      op(1'h1, 8'h37, 8'h01 << n);
      chk(soft_transfer_strobe, 6'h01 << n, "transfer bit");
      chk(chan5_active_hi, (n == 5) ? 8'h3c : 8'h10, "transfer load");
    end
    // reset in mid-run clears everything, no channel stays chosen
    @(posedge clk);
    nrst <= 1'h0;
    @(negedge clk);
    chk_row('0);
    @(posedge clk);
    nrst <= 1'h1;
    op(1'h0, 8'h34, 8'h00);
    chk(rdata, 8'h00, "choice after reset");
    chk(rd_hit, 1'h1, "hit after reset");
    op(1'h1, 8'h33, 8'h55);
    chk(active_copy, 20'h01540, "no copy after reset");
    chk(chan5_active_hi, 8'h00, "chan5 after reset");
    finish_test();
  end
endmodule : test_dac_code_broadcast_regs
`default_nettype wire
